//--- pkg/ebt_consts.svh
`ifndef EBT_CONSTS_SVH
`define EBT_CONSTS_SVH

// Register addresses
`define EBT_ADDR_PORT0_DIR   16'hff20
`define EBT_ADDR_PORT1_DIR   16'hff21
`define EBT_ADDR_PORT3_DIR   16'hff23
`define EBT_ADDR_CMP         16'hff41
`define EBT_ADDR_MODE_CTRL   16'hff43
`define EBT_ADDR_CLK_SEL     16'hff8c
`define EBT_ADDR_PIN_SEL     16'hff70
`define EBT_ADDR_COUNT       16'hff1f

// Mode control field positions
`define EBT_BIT_COUNT_EN     7
`define EBT_BIT_MODE_SEL     6
`define EBT_BIT_FF_SET       3
`define EBT_BIT_FF_CLR       2
`define EBT_BIT_INV_POL      1
`define EBT_BIT_OUT_EN       0

// Reset values
`define EBT_RST_PORT_DIR     8'hff
`define EBT_RST_ZERO8        8'h00
`define EBT_RST_PIN_SEL      2'h0
`define EBT_RST_CLK_SEL      3'h0

// Clock select codes
`define EBT_CS_PIN_FALL      3'h0
`define EBT_CS_PIN_RISE      3'h1
`define EBT_CS_DIV1          3'h2
`define EBT_CS_DIV2          3'h3
`define EBT_CS_DIV16         3'h4
`define EBT_CS_DIV64         3'h5
`define EBT_CS_DIV256        3'h6
`define EBT_CS_EXT           3'h7

// Pin select codes
`define EBT_PIN_NONE         2'h0
`define EBT_PIN_A            2'h1
`define EBT_PIN_B            2'h2

// Counter landmarks
`define EBT_CNT_TOP          8'hff
`define EBT_CNT_PRE_TOP      8'hfe

`endif

//--- pkg/ebt_pkg.sv
package ebt_pkg;

   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
   } ebt_bus_req_t;

   typedef struct packed {
      logic count_en;
      logic mode_sel;
      logic inv_pol;
      logic out_en;
   } ebt_mode_t;

   typedef enum logic [1:0] {
      EBT_PWM_IDLE,
      EBT_PWM_INACTIVE,
      EBT_PWM_ACTIVE
   } ebt_pwm_state_t;

endpackage

//--- design/ebt_count_clock.sv
`timescale 1ns/1ns
`default_nettype none
`include "ebt_consts.svh"

module ebt_count_clock #(
   parameter int PRE_W = 8
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [2:0] clk_sel,
   input  wire logic       event_in,
   input  wire logic       ext_pulse,
   output logic            tick
);
   import ebt_pkg::*;

   logic [PRE_W-1:0] prescale_reg;
   logic             event_d_reg;
   logic             tick_reg;

   // All ones in the low bits marks one slot out of 2^k
   function automatic logic div_hit(input logic [PRE_W-1:0] c, input int k);
      logic hit;
      hit = 1'b1;
      for (int i = 0; i < PRE_W; i++) begin
         if (i < k) begin
            hit = hit & c[i];
         end
      end
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Free-running prescaler; start phase is not aligned, so first tick may jitter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prescale_reg <= '0;
      end else begin
         prescale_reg <= prescale_reg + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         event_d_reg <= 1'b0;
      end else begin
         event_d_reg <= event_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_reg <= 1'b0;
      end else begin
         unique case (clk_sel) // RL14
            `EBT_CS_PIN_FALL: tick_reg <= event_d_reg & ~event_in; // RL16
            `EBT_CS_PIN_RISE: tick_reg <= ~event_d_reg & event_in; // RL16
            `EBT_CS_DIV1:     tick_reg <= 1'b1;
            `EBT_CS_DIV2:     tick_reg <= div_hit(prescale_reg, 1);
            `EBT_CS_DIV16:    tick_reg <= div_hit(prescale_reg, 4);
            `EBT_CS_DIV64:    tick_reg <= div_hit(prescale_reg, 6);
            `EBT_CS_DIV256:   tick_reg <= div_hit(prescale_reg, 8);
            `EBT_CS_EXT:      tick_reg <= ext_pulse;
         endcase
      end
   end

   assign tick = tick_reg;

endmodule // ebt_count_clock
`default_nettype wire

//--- design/ebt_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "ebt_consts.svh"

// Behaviour
// [RL1] Mode bit 0 clear-on-match, 1 PWM
// [RL2] Set/clear bits: 00 hold, 01 low, 10 high
// [RL3] Inversion bit: toggle enable, or PWM polarity
// [RL4] Output enable 0 forces output low
// [RL5] Set/clear bits always read zero
// [RL6] Set/clear bits ignored in PWM mode
// [RL7] Software programs mode register in four steps
// [RL8] No other bit changes while counting
// [RL9] Stopping PWM forces inactive output level
// [RL10] Control bits reach output regardless of counting
// [RL11] Pin select 00 none, 01 A, 10 B
// [RL12] Direction bit 1 input; reset all ones
// [RL13] Match interrupts, clears counter, keeps counting
// [RL14] Three-bit field selects count clock
// [RL15] Interval is compare plus one counts
// [RL16] Event mode counts selected pin edges
// [RL17] Square wave toggles flip-flop each match
// [RL18] Mode bit six selects PWM operation
// [RL19] Compare sets width; bit1 polarity, bit0 gate
// [RL20] Software spaces PWM compare writes three counts
// [RL21] No compare change while clear-mode runs
// [RL22] Count enable 1 starts, 0 stops
// [RL23] PWM active from overflow until compare match
// [RL24] Compare reload at next or second overflow
// [RL25] PWM match raises no interrupt
// [RL26] Counter cleared by reset and stop
module ebt_timer (
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire ebt_pkg::ebt_bus_req_t bus_req,
   output logic [7:0]                 rd_data,
   input  wire logic                  pin_a_in,
   input  wire logic                  pin_b_in,
   input  wire logic                  ext_pulse,
   output logic                       timer_output,
   output logic                       match_interrupt,
   output logic [7:0]                 port0_direction,
   output logic [7:0]                 port1_direction,
   output logic [7:0]                 port3_direction
);
   import ebt_pkg::*;

   ebt_mode_t      mode_reg;
   logic           ff_reg;
   logic [2:0]     clk_sel_reg;
   logic [7:0]     cmp_reg;
   logic [7:0]     cmp_stage_reg;
   logic [7:0]     cmp_act_reg;
   logic [1:0]     pin_sel_reg;
   logic [7:0]     port0_reg;
   logic [7:0]     port1_reg;
   logic [7:0]     port3_reg;
   logic [7:0]     cnt_reg;
   ebt_pwm_state_t pwm_state_reg;
   logic           out_reg;
   logic           irq_reg;
   logic [7:0]     rd_data_reg;

   logic           tick;
   logic           event_in;
   logic           match_clr;
   logic           overflow;
   logic           wr_mode;
   logic           ff_set_wr;
   logic           ff_clr_wr;
   logic           pwm_level;
   logic           out_next;

   // Shared address decode for both write and read paths
   function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] off);
      return a == off;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Event pin routing; the prohibited code behaves as no pin
   always_comb begin
      unique case (pin_sel_reg) // RL11
         `EBT_PIN_A: event_in = pin_a_in;
         `EBT_PIN_B: event_in = pin_b_in;
         default:    event_in = 1'b0;
      endcase
   end

   ebt_count_clock #(
      .PRE_W (8)
   ) u_count_clock (
      .clk       (clk),
      .resetn    (resetn),
      .clk_sel   (clk_sel_reg),
      .event_in  (event_in),
      .ext_pulse (ext_pulse),
      .tick      (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   assign wr_mode   = bus_req.wr && addr_hit(bus_req.addr, `EBT_ADDR_MODE_CTRL);
   // Set/clear only act when the written mode is clear-on-match
   assign ff_set_wr = wr_mode && !bus_req.wdata[`EBT_BIT_MODE_SEL]
                      && bus_req.wdata[`EBT_BIT_FF_SET]
                      && !bus_req.wdata[`EBT_BIT_FF_CLR]; // RL6
   assign ff_clr_wr = wr_mode && !bus_req.wdata[`EBT_BIT_MODE_SEL]
                      && !bus_req.wdata[`EBT_BIT_FF_SET]
                      && bus_req.wdata[`EBT_BIT_FF_CLR]; // RL6

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_reg <= '0;
      end else if (wr_mode) begin
         mode_reg.count_en <= bus_req.wdata[`EBT_BIT_COUNT_EN]; // RL22
         mode_reg.mode_sel <= bus_req.wdata[`EBT_BIT_MODE_SEL]; // RL18
         mode_reg.inv_pol  <= bus_req.wdata[`EBT_BIT_INV_POL];
         mode_reg.out_en   <= bus_req.wdata[`EBT_BIT_OUT_EN];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         clk_sel_reg <= `EBT_RST_CLK_SEL;
         cmp_reg     <= `EBT_RST_ZERO8;
         pin_sel_reg <= `EBT_RST_PIN_SEL;
      end else if (bus_req.wr) begin
         if (addr_hit(bus_req.addr, `EBT_ADDR_CLK_SEL)) begin
            clk_sel_reg <= bus_req.wdata[2:0]; // RL14
         end
         // Software keeps the compare stable while clear-mode runs
         if (addr_hit(bus_req.addr, `EBT_ADDR_CMP)) begin
            cmp_reg <= bus_req.wdata; // RL21
         end
         if (addr_hit(bus_req.addr, `EBT_ADDR_PIN_SEL)) begin
            pin_sel_reg <= bus_req.wdata[1:0]; // RL11
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         port0_reg <= `EBT_RST_PORT_DIR; // RL12
         port1_reg <= `EBT_RST_PORT_DIR; // RL12
         port3_reg <= `EBT_RST_PORT_DIR; // RL12
      end else if (bus_req.wr) begin
         if (addr_hit(bus_req.addr, `EBT_ADDR_PORT0_DIR)) begin
            port0_reg <= bus_req.wdata;
         end
         if (addr_hit(bus_req.addr, `EBT_ADDR_PORT1_DIR)) begin
            port1_reg <= bus_req.wdata;
         end
         if (addr_hit(bus_req.addr, `EBT_ADDR_PORT3_DIR)) begin
            port3_reg <= bus_req.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter
   assign match_clr = mode_reg.count_en && tick && !mode_reg.mode_sel
                      && (cnt_reg == cmp_reg); // RL13
   assign overflow  = mode_reg.count_en && tick && mode_reg.mode_sel
                      && (cnt_reg == `EBT_CNT_TOP);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= `EBT_RST_ZERO8; // RL26
      end else if (!mode_reg.count_en) begin
         cnt_reg <= `EBT_RST_ZERO8; // RL26
      end else if (match_clr) begin
         cnt_reg <= `EBT_RST_ZERO8; // RL15
      end else if (tick) begin
         cnt_reg <= cnt_reg + 8'h01; // RL16
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_reg <= 1'b0;
      end else begin
         // PWM compare never reaches match_clr, so no interrupt there
         irq_reg <= match_clr; // RL25
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output flip-flop; software set/clear only legal while stopped
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ff_reg <= 1'b0;
      end else if (ff_set_wr) begin
         ff_reg <= 1'b1; // RL2
      end else if (ff_clr_wr) begin
         ff_reg <= 1'b0; // RL2
      end else if (match_clr && mode_reg.inv_pol) begin
         ff_reg <= ~ff_reg; // RL17
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PWM compare double buffer; snapshot at count FE decides reload overflow
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cmp_stage_reg <= `EBT_RST_ZERO8;
         cmp_act_reg   <= `EBT_RST_ZERO8;
      end else if (!mode_reg.count_en || !mode_reg.mode_sel) begin
         cmp_stage_reg <= cmp_reg;
         cmp_act_reg   <= cmp_reg;
      end else begin
         if (tick && cnt_reg == `EBT_CNT_PRE_TOP) begin
            cmp_stage_reg <= cmp_reg; // RL24
         end
         // Writes closer than three counts may miss a snapshot
         if (overflow) begin
            cmp_act_reg <= cmp_stage_reg; // RL20
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pwm_state_reg <= EBT_PWM_IDLE;
      end else if (!mode_reg.count_en || !mode_reg.mode_sel) begin
         pwm_state_reg <= EBT_PWM_IDLE; // RL9
      end else begin
         unique case (pwm_state_reg)
            EBT_PWM_IDLE: begin
               pwm_state_reg <= EBT_PWM_INACTIVE; // RL23
            end
            EBT_PWM_INACTIVE: begin
               if (overflow && cmp_stage_reg != `EBT_RST_ZERO8) begin
                  pwm_state_reg <= EBT_PWM_ACTIVE; // RL23
               end
            end
            EBT_PWM_ACTIVE: begin
               if (overflow) begin
                  if (cmp_stage_reg == `EBT_RST_ZERO8) begin
                     pwm_state_reg <= EBT_PWM_INACTIVE;
                  end
               end else if (tick && cnt_reg == cmp_act_reg - 8'h01) begin
                  // Drop on the tick that lands on the compare, so width is N counts
                  pwm_state_reg <= EBT_PWM_INACTIVE; // RL19
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output select; no dependence on count enable except PWM stop
   assign pwm_level = (pwm_state_reg == EBT_PWM_ACTIVE) ^ mode_reg.inv_pol; // RL3

   always_comb begin
      if (!mode_reg.out_en) begin
         out_next = 1'b0; // RL4
      end else if (mode_reg.mode_sel) begin
         out_next = pwm_level; // RL1
      end else begin
         out_next = ff_reg; // RL10
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_reg <= 1'b0;
      end else begin
         out_reg <= out_next; // RL10
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, registered; unmapped reads give zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data_reg <= `EBT_RST_ZERO8;
      end else if (bus_req.rd) begin
         unique case (1'b1)
            addr_hit(bus_req.addr, `EBT_ADDR_MODE_CTRL):
               rd_data_reg <= {mode_reg.count_en, mode_reg.mode_sel, 4'h0,
                               mode_reg.inv_pol, mode_reg.out_en}; // RL5
            addr_hit(bus_req.addr, `EBT_ADDR_CLK_SEL):
               rd_data_reg <= {5'h00, clk_sel_reg};
            addr_hit(bus_req.addr, `EBT_ADDR_CMP):
               rd_data_reg <= cmp_reg;
            addr_hit(bus_req.addr, `EBT_ADDR_COUNT):
               rd_data_reg <= cnt_reg;
            addr_hit(bus_req.addr, `EBT_ADDR_PIN_SEL):
               rd_data_reg <= {6'h00, pin_sel_reg};
            addr_hit(bus_req.addr, `EBT_ADDR_PORT0_DIR):
               rd_data_reg <= port0_reg;
            addr_hit(bus_req.addr, `EBT_ADDR_PORT1_DIR):
               rd_data_reg <= port1_reg;
            addr_hit(bus_req.addr, `EBT_ADDR_PORT3_DIR):
               rd_data_reg <= port3_reg;
            default:
               rd_data_reg <= `EBT_RST_ZERO8;
         endcase
      end
   end

   assign rd_data         = rd_data_reg;
   assign timer_output    = out_reg;
   assign match_interrupt = irq_reg;
   assign port0_direction = port0_reg;
   assign port1_direction = port1_reg;
   assign port3_direction = port3_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   stop_clears_a: assert property ( // RL26
      !mode_reg.count_en |=> cnt_reg == 8'h00)
      else $error("counter not cleared while stopped");

   match_irq_a: assert property ( // RL13
      match_clr |=> irq_reg && cnt_reg == 8'h00)
      else $error("match did not interrupt and clear");

   out_gate_a: assert property ( // RL4
      !mode_reg.out_en |=> !timer_output)
      else $error("output not low while disabled");

   pwm_no_irq_a: assert property ( // RL25
      mode_reg.mode_sel |=> !match_interrupt)
      else $error("interrupt raised in PWM mode");

   lv_read_zero_a: assert property ( // RL5
      bus_req.rd && addr_hit(bus_req.addr, `EBT_ADDR_MODE_CTRL)
      |=> rd_data[3:2] == 2'b00)
      else $error("set/clear bits read nonzero");

   ff_set_a: assert property ( // RL2
      ff_set_wr |=> ff_reg ##1 timer_output == mode_reg.out_en)
      else $error("flip-flop set not applied");

   ff_toggle_a: assert property ( // RL3
      match_clr && mode_reg.inv_pol && !wr_mode |=> ff_reg != $past(ff_reg))
      else $error("flip-flop did not toggle on match");

   ff_pwm_hold_a: assert property ( // RL6
      wr_mode && bus_req.wdata[`EBT_BIT_MODE_SEL] && !match_clr
      |=> ff_reg == $past(ff_reg))
      else $error("set/clear applied in PWM mode");

   pwm_stop_a: assert property ( // RL9
      pwm_state_reg == EBT_PWM_IDLE && mode_reg.mode_sel && mode_reg.out_en
      |=> timer_output == $past(mode_reg.inv_pol))
      else $error("stopped PWM output not inactive");

   pwm_start_a: assert property ( // RL23
      pwm_state_reg == EBT_PWM_ACTIVE && $past(pwm_state_reg) != EBT_PWM_ACTIVE
      |-> $past(overflow))
      else $error("PWM active without overflow");

   cmp_reload_a: assert property ( // RL24
      overflow |=> cmp_act_reg == $past(cmp_stage_reg))
      else $error("compare not reloaded at overflow");

   square_wave_c: cover property (match_clr && mode_reg.inv_pol && mode_reg.out_en);
   pwm_active_c: cover property (pwm_state_reg == EBT_PWM_ACTIVE && timer_output);
   event_count_c: cover property (tick && clk_sel_reg == `EBT_CS_PIN_RISE);
   pin_b_c: cover property (pin_sel_reg == `EBT_PIN_B && match_clr);

endmodule // ebt_timer
`default_nettype wire

//--- verification/ebt_event_src.sv
`timescale 1ns/1ns
`default_nettype none

module ebt_event_src (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [1:0] sel,
   input  wire logic [7:0] period,
   output logic            pin_a,
   output logic            pin_b,
   output logic            ext_pulse
);

   logic [7:0] cnt_reg;
   logic       lvl_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Period zero keeps the source quiet; period must be two or more
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= 8'h00;
         lvl_reg <= 1'b0;
      end else if (period == 8'h00) begin
         cnt_reg <= 8'h00;
      end else if (cnt_reg == period - 8'h01) begin
         cnt_reg <= 8'h00;
         lvl_reg <= ~lvl_reg;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Unused pin idles high, as with a pull-up
   assign pin_a     = (sel == 2'h1) ? lvl_reg : 1'b1;
   assign pin_b     = (sel == 2'h2) ? lvl_reg : 1'b1;
   assign ext_pulse = (period != 8'h00) && (cnt_reg == 8'h00);

endmodule // ebt_event_src

`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ebt_consts.svh"

`define CHK(got, exp) \
   begin compares++; if ((got) !== (exp)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_top;
   import ebt_pkg::*;

   logic           clk;
   logic           resetn;
   ebt_bus_req_t   bus_req;
   logic [7:0]     rd_data;
   logic           pin_a;
   logic           pin_b;
   logic           ext_pulse;
   logic           timer_output;
   logic           match_interrupt;
   logic [7:0]     port0_direction;
   logic [7:0]     port1_direction;
   logic [7:0]     port3_direction;
   logic [1:0]     src_sel;
   logic [7:0]     src_period;
   int             err_count = 0;
   int             compares = 0;
   int             irq_seen = 0;

   ebt_timer ebt_timer_inst (
      .clk(clk), .resetn(resetn), .bus_req(bus_req), .rd_data(rd_data),
      .pin_a_in(pin_a), .pin_b_in(pin_b), .ext_pulse(ext_pulse),
      .timer_output(timer_output), .match_interrupt(match_interrupt),
      .port0_direction(port0_direction), .port1_direction(port1_direction),
      .port3_direction(port3_direction)
   );

   ebt_event_src ebt_event_src_inst (
      .clk(clk), .resetn(resetn), .sel(src_sel), .period(src_period),
      .pin_a(pin_a), .pin_b(pin_b), .ext_pulse(ext_pulse)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (match_interrupt === 1'b1) begin
         irq_seen++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus and wait helpers
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1 d = rd_data;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Cycles up to the next interrupt, zero if none comes in time
   task automatic wait_irq(input int lim, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (match_interrupt !== 1'b1 && n < lim);
      if (match_interrupt !== 1'b1) n = 0;
   endtask

   task automatic hold(input logic v, output int n);
      n = 0;
      while (timer_output === v && n < 600) begin
         @(posedge clk);
         #1 n++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      logic [7:0]  d;
      logic [15:0] pa [3] = '{`EBT_ADDR_PORT0_DIR, `EBT_ADDR_PORT1_DIR, `EBT_ADDR_PORT3_DIR};
      foreach (pa[i]) begin
         rd(pa[i], d);
         `CHK(d, 8'hff)
      end
      rd(`EBT_ADDR_PIN_SEL, d);
      `CHK(d, 8'h00)
      rd(`EBT_ADDR_MODE_CTRL, d);
      `CHK(d, 8'h00)
      `CHK({timer_output, match_interrupt}, 2'b00)
      wr(`EBT_ADDR_PORT1_DIR, 8'h5a);
      rd(`EBT_ADDR_PORT1_DIR, d);
      `CHK(d, 8'h5a)
      `CHK({port0_direction, port1_direction, port3_direction}, 24'hff5aff)
      rd(16'hff00, d);
      `CHK(d, 8'h00)
      $display("test reset done");
   endtask

   task automatic t_ffbits();
      logic [7:0] d;
      logic [7:0] wv [6] = '{8'h09, 8'h01, 8'h00, 8'h01, 8'h05, 8'h01};
      logic       ev [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      // Stopped timer: every write must reach the pin
      foreach (wv[i]) begin
         wr(`EBT_ADDR_MODE_CTRL, wv[i]);
         cyc(2);
         `CHK(timer_output, ev[i])
      end
      wr(`EBT_ADDR_MODE_CTRL, 8'h09);
      rd(`EBT_ADDR_MODE_CTRL, d);
      `CHK(d, 8'h01)
      $display("test flip-flop done");
   endtask

   task automatic t_square();
      int         n;
      logic [7:0] d;
      logic       o;
      wr(`EBT_ADDR_MODE_CTRL, 8'h00);
      wr(`EBT_ADDR_CLK_SEL, {5'h00, `EBT_CS_DIV1});
      wr(`EBT_ADDR_CMP, 8'h04);
      wr(`EBT_ADDR_MODE_CTRL, 8'h02);
      wr(`EBT_ADDR_MODE_CTRL, 8'h03);
      wr(`EBT_ADDR_MODE_CTRL, 8'h07);
      wr(`EBT_ADDR_MODE_CTRL, 8'h83);
      wait_irq(600, n);
      wait_irq(600, n);
      `CHK(n, 5)
      cyc(2);
      o = timer_output;
      wait_irq(600, n);
      cyc(2);
      `CHK(timer_output, ~o)
      wr(`EBT_ADDR_MODE_CTRL, 8'h03);
      cyc(2);
      rd(`EBT_ADDR_COUNT, d);
      `CHK(d, 8'h00)
      wait_irq(20, n);
      `CHK(n, 0)
      $display("test square done");
   endtask

   task automatic t_clocks();
      int         n;
      logic [2:0] cs [9] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h0, 3'h1};
      logic [1:0] ps [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
      logic [7:0] sp [9] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h3, 8'h3, 8'h5, 8'h3};
      int         ex [9] = '{2, 4, 32, 128, 512, 6, 12, 20, 0};
      // Compare of one: two ticks per interrupt
      foreach (cs[i]) begin
         wr(`EBT_ADDR_MODE_CTRL, 8'h00);
         wr(`EBT_ADDR_CLK_SEL, {5'h00, cs[i]});
         wr(`EBT_ADDR_PIN_SEL, {6'h00, ps[i]});
         src_sel <= (ps[i] == 2'h0) ? 2'h1 : ps[i];
         src_period <= sp[i];
         wr(`EBT_ADDR_CMP, 8'h01);
         wr(`EBT_ADDR_MODE_CTRL, 8'h80);
         wait_irq(1200, n);
         wait_irq(1200, n);
         `CHK(n, ex[i])
      end
      wr(`EBT_ADDR_MODE_CTRL, 8'h00);
      src_period <= 8'h00;
      $display("test clocks done");
   endtask

   task automatic t_pwm();
      int         w;
      int         g;
      logic [7:0] d;
      wr(`EBT_ADDR_CLK_SEL, {5'h00, `EBT_CS_DIV1});
      wr(`EBT_ADDR_CMP, 8'h40);
      wr(`EBT_ADDR_MODE_CTRL, 8'h40);
      wr(`EBT_ADDR_MODE_CTRL, 8'h41);
      wr(`EBT_ADDR_MODE_CTRL, 8'hc1);
      irq_seen = 0;
      cyc(2);
      `CHK(timer_output, 1'b0)
      hold(1'b0, g);
      hold(1'b1, w);
      hold(1'b0, g);
      `CHK(w, 64)
      `CHK(w + g, 256)
      // Written early in the count, so the next pulse uses it
      wr(`EBT_ADDR_CMP, 8'h20);
      hold(1'b1, g);
      hold(1'b0, g);
      hold(1'b1, w);
      `CHK(w, 32)
      `CHK(irq_seen, 0)
      // Stop inside an active phase so the forced level shows
      hold(1'b0, g);
      wr(`EBT_ADDR_MODE_CTRL, 8'h41);
      cyc(2);
      `CHK(timer_output, 1'b0)
      rd(`EBT_ADDR_COUNT, d);
      `CHK(d, 8'h00)
      wr(`EBT_ADDR_MODE_CTRL, 8'h43);
      cyc(2);
      `CHK(timer_output, 1'b1)
      wr(`EBT_ADDR_MODE_CTRL, 8'h42);
      cyc(2);
      `CHK(timer_output, 1'b0)
      wr(`EBT_ADDR_MODE_CTRL, 8'h09);
      wr(`EBT_ADDR_MODE_CTRL, 8'h49);
      cyc(2);
      `CHK(timer_output, 1'b0)
      // Clear bit written in PWM must not reach the flip-flop
      wr(`EBT_ADDR_MODE_CTRL, 8'h45);
      wr(`EBT_ADDR_MODE_CTRL, 8'h01);
      cyc(2);
      `CHK(timer_output, 1'b1)
      $display("test pwm done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Run control
   task automatic end_sim();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Longest case is the no-pin event case, which runs out both waits; the whole run needs far less
   initial begin
      #(60000 * 10);
      err_count++;
      end_sim();
   end

   initial begin
      resetn = 1'b0;
      bus_req = '0;
      src_sel = 2'h1;
      src_period = 8'h00;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_ffbits();
      t_square();
      t_clocks();
      t_pwm();
      end_sim();
   end

endmodule // tb_top

`default_nettype wire
